//--- core/spsd_pkg.sv
// Package of constants and types for the stepper driver serial port.
// Assumes a 40 MHz system clock and a host-driven serial clock.
package spsd_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int SYS_CLK_KHZ = 40000;
  localparam int REV_DELAY_US = 1000;
  localparam int REV_DELAY_CYC = (REV_DELAY_US * SYS_CLK_KHZ) / 1000;
  localparam int WAKE_SETUP_US = 30;
  localparam logic [3:0] READY_SCK = 4'ha;
  localparam logic [2:0] BYTE_MOD_ZERO = 3'h0;

  // ----------------------------------------------------------------
  // Command and response fields
  // ----------------------------------------------------------------
  localparam int CMD_A_RANGE_HI = 5;
  localparam int CMD_A_RANGE_LO = 4;
  localparam int CMD_A_POL = 3;
  localparam int CMD_B_RANGE_HI = 2;
  localparam int CMD_B_RANGE_LO = 1;
  localparam int CMD_B_POL = 0;
  localparam int RESP_ERR_HI = 7;
  localparam int RESP_ERR_LO = 6;

  localparam logic [1:0] ERR_NORMAL = 2'h3;
  localparam logic [1:0] ERR_LOW_DOM = 2'h1;
  localparam logic [1:0] ERR_GND = 2'h2;
  localparam logic [1:0] ERR_THERM = 2'h0;
  localparam logic [5:0] OP_RESET = 6'h3f;
  localparam logic [7:0] RESP_STANDBY = 8'hff;
  localparam logic [7:0] SHIFT_RESET = 8'hff;
  localparam logic [1:0] RANGE_OFF = 2'h3;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0] range;
    logic pol;
  } spsd_bcmd_t;

  typedef struct packed {
    logic first;
    logic second;
  } spsd_bout_t;

  typedef struct packed {
    logic open_a;
    logic open_b;
    logic [3:0] short_vs;
    logic [3:0] short_gnd;
    logic pre_alarm;
    logic shutdown;
  } spsd_fault_t;

endpackage

//--- core/spsd_sync.sv
// Three-stage synchroniser for a level from another clock domain.
// Output follows once the second and third stages agree.
`timescale 1ns/1ps
module spsd_sync #(
  parameter logic INIT = 1'b0
) (
  input wire logic clk,   // destination clock
  input wire logic rst_n, // asynchronous reset, active low
  input wire logic d,     // asynchronous level
  output logic q          // filtered synchronous level
);
  logic s1_reg;
  logic s2_reg;
  logic s3_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_reg <= INIT;
      s2_reg <= INIT;
      s3_reg <= INIT;
      q <= INIT;
    end else begin
      s1_reg <= d;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg) begin
        q <= s3_reg;
      end
    end
  end
endmodule

//--- core/spsd_bridge.sv
// One full bridge: applies range and polarity, with an off gap on reversal.
// Assumes command and enable come from the system clock domain.
`timescale 1ns/1ps
module spsd_bridge
  import spsd_pkg::*;
#(
  parameter int REV_CYC = REV_DELAY_CYC
) (
  input wire logic sys_clk,          // system clock
  input wire logic rst_n,            // asynchronous reset, active low
  input wire logic run,              // bridge may conduct
  input spsd_pkg::spsd_bcmd_t cmd,   // requested range and polarity
  output spsd_pkg::spsd_bcmd_t cur,  // applied range and polarity
  output spsd_pkg::spsd_bout_t bout  // the two bridge outputs
);
  localparam int CW = $clog2(REV_CYC + 1);
  localparam logic [CW-1:0] GAP = CW'(REV_CYC);

  spsd_bcmd_t cur_reg;
  logic [CW-1:0] gap_reg;
  logic cur_on;
  logic cmd_on;

  assign cur_on = (cur_reg.range != RANGE_OFF);
  assign cmd_on = (cmd.range != RANGE_OFF);
  assign cur = cur_reg;

  // ----------------------------------------------------------------
  // Apply commands, turning off first on reversal
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cur_reg <= '{range: RANGE_OFF, pol: 1'b0};
      gap_reg <= '0;
    end else if (!run) begin
      cur_reg.range <= RANGE_OFF;
      gap_reg <= '0;
    end else if (gap_reg != '0) begin
      gap_reg <= gap_reg - 1'b1;
      if (gap_reg == 1) begin
        cur_reg <= cmd; // see (RULE15)
      end
    end else if (cur_on && cmd_on && cmd.pol != cur_reg.pol) begin
      cur_reg.range <= RANGE_OFF; // see (RULE15)
      gap_reg <= GAP;
    end else begin
      cur_reg <= cmd;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      bout <= '0;
    end else begin
      bout.first <= cur_on & cur_reg.pol;
      bout.second <= cur_on & ~cur_reg.pol;
    end
  end

  AST_REV_GAP: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (cur_on && $past(cur_on)) |-> cur_reg.pol == $past(cur_reg.pol))
    else $error("bridge reversed without off gap"); // see (RULE15)
endmodule

//--- core/spsd_serial_ctrl.sv
// Serial control and diagnosis port of a two-phase stepper driver.
// Assumes the host drives spi_clk only inside frames and meets setup times.
`timescale 1ns/1ps

// Rules from the document
// (RULE1) Wake on enable fall, ready after ten clocks
// (RULE2) Host waits 30 us before first clock
// (RULE3) Frame starts on select fall; sample rising
// (RULE4) Shift response bit out on falling edge
// (RULE5) Commit on select rise if falls mod 8
// (RULE6) Otherwise discard bits, bridges unchanged
// (RULE7) Serial output driven only while selected
// (RULE8) Bits 5 and 4 set bridge A range
// (RULE9) Bits 2 and 1 set bridge B range
// (RULE10) Bit 3 A polarity, bit 0 B polarity
// (RULE11) Response bits 7,6 are error flags
// (RULE12) Response is last code; standby gives all ones
// (RULE13) Daisy chain passes bytes through shift register
// (RULE14) Host selects one parallel device at once
// (RULE15) Reversal turns bridge off before reverse on
// (RULE16) Same-level faults combine by bitwise AND
// (RULE17) Open and short-to-supply give pair 01
// (RULE18) Short to ground overrides lower faults
// (RULE19) Thermal faults override every other code
// (RULE20) Pre-alarm gives 00, keeps operating code
// (RULE21) Ground short on both branches gives 10
// (RULE22) Error latches clear at committing select rise
// (RULE23) Pairs: 11 ok, 01 low, 10 ground, 00 thermal
// (RULE24) Shutdown turns off, 00 with ones code
// (RULE25) Bytes travel most significant bit first
module spsd_serial_ctrl
  import spsd_pkg::*;
#(
  parameter int REV_CYC = REV_DELAY_CYC
) (
  input wire logic sys_clk,                // system clock, 40 MHz
  input wire logic rst_n,                  // asynchronous reset
  input wire logic spi_clk,                // serial clock from host
  input wire logic active_low_enable,      // high puts device in standby
  input wire logic frame_select_n,         // frame select, active low
  input wire logic sdi,                    // serial data in
  output logic sdo_out,                    // serial data out level
  output logic sdo_oe,                     // serial data out enable
  input spsd_pkg::spsd_fault_t fault,      // fault detectors, sys_clk
  output spsd_pkg::spsd_bout_t bridge_a,   // bridge A outputs
  output spsd_pkg::spsd_bout_t bridge_b,   // bridge B outputs
  output spsd_pkg::spsd_bcmd_t applied_a,  // bridge A applied setting
  output spsd_pkg::spsd_bcmd_t applied_b,  // bridge B applied setting
  output logic [5:0] op_code,              // accepted operating code
  output logic [1:0] err_pair,             // current error pair
  output logic device_ready                // awake and ready for frames
);

  // ----------------------------------------------------------------
  // Link domain: wake counter and shifter
  // ----------------------------------------------------------------
  logic link_rst_n;
  logic [3:0] rdy_cnt_reg;
  logic rdy_reg;
  logic pfresh_reg;
  logic nfresh_reg;
  logic [7:0] sh_reg;
  logic [2:0] fall_mod_reg;
  logic tog_reg;
  logic sdo_q_reg;
  logic [7:0] resp_reg;

  // Standby holds the link logic in reset
  assign link_rst_n = rst_n & ~active_low_enable;

  always_ff @(posedge spi_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      rdy_cnt_reg <= 4'h0;
      rdy_reg <= 1'b0;
    end else if (rdy_cnt_reg != READY_SCK) begin
      rdy_cnt_reg <= rdy_cnt_reg + 4'h1; // see (RULE1)
      rdy_reg <= (rdy_cnt_reg + 4'h1) == READY_SCK;
    end
  end

  // Set while deselected, so the first edge of a frame is known
  always_ff @(posedge spi_clk or posedge frame_select_n) begin
    if (frame_select_n) begin
      pfresh_reg <= 1'b1; // see (RULE3)
    end else begin
      pfresh_reg <= 1'b0;
    end
  end

  always_ff @(negedge spi_clk or posedge frame_select_n) begin
    if (frame_select_n) begin
      nfresh_reg <= 1'b1;
    end else begin
      nfresh_reg <= 1'b0;
    end
  end

  // One shift register serves input, output and chaining
  always_ff @(posedge spi_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      sh_reg <= SHIFT_RESET;
    end else if (pfresh_reg) begin
      sh_reg <= {resp_reg[6:0], sdi}; // see (RULE3) (RULE25)
    end else begin
      sh_reg <= {sh_reg[6:0], sdi}; // see (RULE13) (RULE25)
    end
  end

  // Marks a frame that started after the wake time
  always_ff @(posedge spi_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      tog_reg <= 1'b0;
    end else if (pfresh_reg && rdy_reg) begin
      tog_reg <= ~tog_reg; // see (RULE1)
    end
  end

  always_ff @(negedge spi_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      fall_mod_reg <= 3'h0;
    end else if (nfresh_reg) begin
      fall_mod_reg <= 3'h1; // see (RULE5)
    end else begin
      fall_mod_reg <= fall_mod_reg + 3'h1;
    end
  end

  always_ff @(negedge spi_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      sdo_q_reg <= 1'b1;
    end else begin
      sdo_q_reg <= sh_reg[7]; // see (RULE4)
    end
  end

  // Before the first falling edge the response MSB is presented
  assign sdo_out = nfresh_reg ? resp_reg[7] : sdo_q_reg; // see (RULE25)
  assign sdo_oe = ~frame_select_n & ~active_low_enable; // see (RULE7)

  // ----------------------------------------------------------------
  // Crossing into the system domain
  // ----------------------------------------------------------------
  logic sel_n_s;
  logic stby_s;
  logic tog_s;
  logic rdy_s;

  spsd_sync #(.INIT(1'b1)) u_sync_sel (
    .clk(sys_clk),
    .rst_n(rst_n),
    .d(frame_select_n),
    .q(sel_n_s)
  );

  spsd_sync #(.INIT(1'b1)) u_sync_stby (
    .clk(sys_clk),
    .rst_n(rst_n),
    .d(active_low_enable),
    .q(stby_s)
  );

  spsd_sync #(.INIT(1'b0)) u_sync_tog (
    .clk(sys_clk),
    .rst_n(rst_n),
    .d(tog_reg),
    .q(tog_s)
  );

  spsd_sync #(.INIT(1'b0)) u_sync_rdy (
    .clk(sys_clk),
    .rst_n(rst_n),
    .d(rdy_reg),
    .q(rdy_s)
  );

  // ----------------------------------------------------------------
  // Frame end and command commit
  // ----------------------------------------------------------------
  logic sel_prev_reg;
  logic seen_tog_reg;
  logic sel_rise;
  logic frame_had_edges;
  logic commit;
  logic discard;
  logic [5:0] op_reg;

  // Shift register and count are quiet once the link clock stops
  assign sel_rise = sel_n_s & ~sel_prev_reg;
  assign frame_had_edges = (tog_s != seen_tog_reg);
  assign commit = sel_rise & frame_had_edges & ~stby_s &
                  (fall_mod_reg == BYTE_MOD_ZERO); // see (RULE5)
  assign discard = sel_rise & frame_had_edges & ~commit; // see (RULE6)

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sel_prev_reg <= 1'b1;
      seen_tog_reg <= 1'b0;
    end else begin
      sel_prev_reg <= sel_n_s;
      if (sel_rise) begin
        seen_tog_reg <= tog_s;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      op_reg <= OP_RESET;
    end else if (stby_s) begin
      op_reg <= OP_RESET;
    end else if (commit) begin
      op_reg <= sh_reg[5:0]; // see (RULE5) (RULE11)
    end
  end

  // ----------------------------------------------------------------
  // Fault latches and dominance
  // ----------------------------------------------------------------
  spsd_fault_t lat_reg;
  logic [1:0] err_c;
  logic low_any;
  logic gnd_any;
  logic therm_any;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      lat_reg <= '0;
    end else if (stby_s) begin
      lat_reg <= '0;
    end else if (commit) begin
      lat_reg <= fault; // see (RULE22)
    end else begin
      lat_reg <= lat_reg | fault;
    end
  end

  assign low_any = lat_reg.open_a | lat_reg.open_b | (|lat_reg.short_vs);
  assign gnd_any = |lat_reg.short_gnd;
  assign therm_any = lat_reg.pre_alarm | lat_reg.shutdown;

  // AND of equal-rank codes equals that rank's code
  always_comb begin
    if (therm_any) begin
      err_c = ERR_THERM; // see (RULE19) (RULE20) (RULE24)
    end else if (gnd_any) begin
      err_c = ERR_GND; // see (RULE18) (RULE21)
    end else if (low_any) begin
      err_c = ERR_LOW_DOM; // see (RULE16) (RULE17)
    end else begin
      err_c = ERR_NORMAL; // see (RULE23)
    end
  end

  // ----------------------------------------------------------------
  // Response word, frozen while a frame runs
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      resp_reg <= RESP_STANDBY;
    end else if (stby_s) begin
      resp_reg <= RESP_STANDBY; // see (RULE12)
    end else if (sel_n_s && !sel_rise) begin
      resp_reg[RESP_ERR_HI:RESP_ERR_LO] <= err_c; // see (RULE11)
      resp_reg[5:0] <= lat_reg.shutdown ? OP_RESET : op_reg; // see (RULE24)
    end
  end

  // ----------------------------------------------------------------
  // Bridges
  // ----------------------------------------------------------------
  spsd_bcmd_t cmd_a;
  spsd_bcmd_t cmd_b;
  logic run;

  assign cmd_a.range = op_reg[CMD_A_RANGE_HI:CMD_A_RANGE_LO]; // see (RULE8)
  assign cmd_a.pol = op_reg[CMD_A_POL]; // see (RULE10)
  assign cmd_b.range = op_reg[CMD_B_RANGE_HI:CMD_B_RANGE_LO]; // see (RULE9)
  assign cmd_b.pol = op_reg[CMD_B_POL]; // see (RULE10)
  assign run = ~stby_s & ~fault.shutdown; // see (RULE24)

  spsd_bridge #(.REV_CYC(REV_CYC)) u_bridge_a (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .run(run),
    .cmd(cmd_a),
    .cur(applied_a),
    .bout(bridge_a)
  );

  spsd_bridge #(.REV_CYC(REV_CYC)) u_bridge_b (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .run(run),
    .cmd(cmd_b),
    .cur(applied_b),
    .bout(bridge_b)
  );

  // ----------------------------------------------------------------
  // Status outputs
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      op_code <= OP_RESET;
      err_pair <= ERR_NORMAL;
      device_ready <= 1'b0;
    end else begin
      op_code <= op_reg;
      err_pair <= err_c;
      device_ready <= rdy_s & ~stby_s; // see (RULE1)
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  AST_COMMIT_MOD8: assert property (@(posedge sys_clk) disable iff (!rst_n)
    commit |=> op_reg == $past(sh_reg[5:0]))
    else $error("commit did not load the received code"); // see (RULE5)

  AST_DISCARD_HOLD: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (sel_rise && fall_mod_reg != BYTE_MOD_ZERO && !stby_s)
      |=> op_reg == $past(op_reg))
    else $error("partial frame changed the code"); // see (RULE6)

  AST_STANDBY_RESP: assert property (@(posedge sys_clk) disable iff (!rst_n)
    stby_s |=> resp_reg == RESP_STANDBY && op_reg == OP_RESET)
    else $error("standby response not all ones"); // see (RULE12)

  AST_THERM_DOM: assert property (@(posedge sys_clk) disable iff (!rst_n)
    therm_any |=> err_pair == ERR_THERM)
    else $error("thermal code not dominant"); // see (RULE19)

  AST_GND_DOM: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (gnd_any && !therm_any) |=> err_pair == ERR_GND)
    else $error("ground short not above low faults"); // see (RULE18)

  AST_LOW_CODE: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (low_any && !gnd_any && !therm_any) |=> err_pair == ERR_LOW_DOM)
    else $error("open or supply short not 01"); // see (RULE17)

  AST_SHUTDOWN_OP: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (lat_reg.shutdown && sel_n_s && !sel_rise && !stby_s)
      |=> resp_reg == {ERR_THERM, OP_RESET})
    else $error("shutdown response wrong"); // see (RULE24)

  AST_LATCH_CLEAR: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (commit && !stby_s) |=> lat_reg == $past(fault))
    else $error("error latch not cleared on commit"); // see (RULE22)

  AST_SHIFT_OUT: assert property (@(negedge spi_clk)
    disable iff (!link_rst_n || frame_select_n)
    !nfresh_reg |=> sdo_q_reg == $past(sh_reg[7]))
    else $error("response bit not shifted on falling edge"); // see (RULE4)

  AST_READY10: assert property (@(posedge spi_clk) disable iff (!link_rst_n)
    rdy_reg |-> rdy_cnt_reg == READY_SCK)
    else $error("ready before ten serial clocks"); // see (RULE1)

  COV_COMMIT: cover property (@(posedge sys_clk) disable iff (!rst_n)
    commit);
  COV_DISCARD: cover property (@(posedge sys_clk) disable iff (!rst_n)
    discard);
  COV_GND_ERR: cover property (@(posedge sys_clk) disable iff (!rst_n)
    sel_rise && err_c == ERR_GND);
  COV_REVERSE: cover property (@(posedge sys_clk) disable iff (!rst_n)
    bridge_a.first ##[1:8] !bridge_a.first && !bridge_a.second);

endmodule

//--- testbench/spsd_host_model.sv
// Host side of the serial control link: frames, bit shifting, setup wait.
// Assumes the bench resolves the data-out line and drives the enable pin.
`timescale 1ns/1ps
module spsd_host_model (
  output logic spi_clk,        // serial clock, still outside frames
  output logic frame_select_n, // frame select, active low
  output logic sdi,            // serial data towards the device
  input wire logic sdo         // resolved serial data from the device
);
  localparam time HALF = 16ns;

  initial begin
    spi_clk = 1'b0;
    frame_select_n = 1'b1;
    sdi = 1'b0;
  end

  // ------------------------------------------------------------
  // Wait after wake before the first clock edge
  // ------------------------------------------------------------
  task automatic setup_wait();
    #30us;
  endtask

  // ------------------------------------------------------------
  // One frame, MSB first; response sampled on each rising edge
  // ------------------------------------------------------------
  task automatic frame(input int nbits, input logic [15:0] data,
                       output logic [15:0] resp);
    resp = 16'h0000;
    frame_select_n = 1'b0;
    #(2 * HALF);
    for (int i = nbits - 1; i >= 0; i--) begin
      sdi = data[i];
      #HALF;
      spi_clk = 1'b1;
      resp = {resp[14:0], sdo};
      #HALF;
      spi_clk = 1'b0;
    end
    #(2 * HALF);
    frame_select_n = 1'b1;
    sdi = ~sdi;
    #300ns;
  endtask
endmodule

//--- testbench/spsd_serial_ctrl_tb.sv
// Self-checking bench for the stepper driver serial control port.
// Assumes the host model drives the link and the bench drives pins.
`timescale 1ns/1ps
module spsd_serial_ctrl_tb;
  import spsd_pkg::*;
  localparam int REV = 20;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic active_low_enable = 1'b1;
  spsd_fault_t fault = '0;
  logic spi_clk, frame_select_n, sdi, sdo_out, sdo_oe, device_ready;
  logic sdo_last = 1'b0;
  wire sdo_line = sdo_oe ? sdo_out : ~sdo_last;
  spsd_bout_t bridge_a, bridge_b;
  spsd_bcmd_t applied_a, applied_b;
  logic [5:0] op_code;
  logic [1:0] err_pair;
  logic [15:0] rsp;
  int failures = 0;
  int n_checks = 0;
  spsd_fault_t ftab [6] = '{12'h800, 12'he00, 12'h030, 12'h820,
                            12'h022, 12'h001};
  logic [1:0] etab [6] = '{2'h1, 2'h1, 2'h2, 2'h2, 2'h0, 2'h0};
  int nbad [4] = '{0, 7, 9, 15};

  always #12.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (sdo_oe) sdo_last <= sdo_out;
  // Data out is driven on every rising edge inside an awake frame
  always @(posedge spi_clk) begin
    if (!frame_select_n) check(sdo_oe, !active_low_enable);
  end

  spsd_serial_ctrl #(.REV_CYC(REV)) u_dut (
    .sys_clk(sys_clk), .rst_n(rst_n), .spi_clk(spi_clk),
    .active_low_enable(active_low_enable),
    .frame_select_n(frame_select_n), .sdi(sdi), .sdo_out(sdo_out),
    .sdo_oe(sdo_oe), .fault(fault), .bridge_a(bridge_a),
    .bridge_b(bridge_b), .applied_a(applied_a), .applied_b(applied_b),
    .op_code(op_code), .err_pair(err_pair), .device_ready(device_ready)
  );

  spsd_host_model u_host (
    .spi_clk(spi_clk), .frame_select_n(frame_select_n), .sdi(sdi),
    .sdo(sdo_line)
  );

  // ------------------------------------------------------------
  // Comparison and closing
  // ------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic xfer(input int n, input logic [15:0] d, input int w);
    u_host.frame(n, d, rsp);
    repeat (w) @(negedge sys_clk);
  endtask

  initial begin
    #1ms;
    failures++;
    wrap_up();
  end

  // ------------------------------------------------------------
  // Test sequence
  // ------------------------------------------------------------
  initial begin
    repeat (8) @(negedge sys_clk);
    rst_n = 1'b1;
    @(negedge sys_clk);
    check(op_code, OP_RESET);
    check(err_pair, ERR_NORMAL);
    check(sdo_oe, 1'b0);
    active_low_enable = 1'b0;
    u_host.setup_wait();
    xfer(9, 16'h01ff, 12);
    check(device_ready, 1'b0);
    xfer(8, 16'h0000, 12);
    check(device_ready, 1'b1);
    check(op_code, OP_RESET);
    // First command after standby, bits 7 and 6 set
    xfer(8, 16'h00db, 30);
    check(rsp[7:0], RESP_STANDBY);
    check(op_code, 6'h1b);
    check(applied_a, 3'b011);
    check(applied_b, 3'b011);
    check(bridge_a, 2'b10);
    check(bridge_b, 2'b10);
    check(sdo_oe, 1'b0);
    // Polarity reversal on bridge A
    xfer(8, 16'h0013, 8);
    check(rsp[7:0], 8'hdb);
    check(bridge_a, 2'b00);
    repeat (30) @(negedge sys_clk);
    check(bridge_a, 2'b01);
    check(applied_a, 3'b010);
    // Frames with no edges or an edge count that is not a whole number of bytes
    for (int i = 0; i < 4; i++) begin
      xfer(nbad[i], 16'h7fc0, 12);
      check(op_code, 6'h13);
      check(applied_a, 3'b010);
    end
    // Two-byte chain frame: second byte commits, first passes on
    xfer(16, 16'h5a2d, 40);
    check(rsp, 16'hd35a);
    check(op_code, 6'h2d);
    // Fault codes and their dominance
    for (int i = 0; i < 6; i++) begin
      fault = ftab[i];
      repeat (4) @(negedge sys_clk);
      if (i >= 4) check(bridge_a, i == 4 ? 2'h2 : 2'h0);
      fault = '0;
      repeat (4) @(negedge sys_clk);
      check(err_pair, etab[i]);
      xfer(8, 16'h002d, 12);
      check(rsp[7:0], {etab[i], i == 5 ? 6'h3f : 6'h2d});
      check(err_pair, ERR_NORMAL);
      check(op_code, 6'h2d);
    end
    // Back to standby: code reset, bridge A off, frames refused
    active_low_enable = 1'b1;
    repeat (12) @(negedge sys_clk);
    check(op_code, OP_RESET);
    check(bridge_a, 2'b00);
    check(device_ready, 1'b0);
    xfer(8, 16'h0012, 12);
    check(op_code, OP_RESET);
    wrap_up();
  end
endmodule
